// ---- dtrig_pkg.sv ----
// Shared constants and types of the digitizer trigger logic.
// Assumes one sampling clock; samples are signed two's complement words.
package dtrig_pkg;

	localparam int DTRIG_NUM_CH      = 2;
	localparam int DTRIG_ENG_PER_CH  = 2;
	localparam int DTRIG_NUM_ENG     = DTRIG_NUM_CH * DTRIG_ENG_PER_CH + 1;
	localparam int DTRIG_EXT_ENG     = DTRIG_NUM_ENG - 1;
	localparam int DTRIG_NUM_INPUTS  = DTRIG_NUM_CH + 1;
	localparam int DTRIG_EXT_IDX     = DTRIG_NUM_CH;

	localparam int DTRIG_SAMPLE_W    = 16;
	localparam int DTRIG_NARROW_W    = 14;
	localparam int DTRIG_PAD_W       = DTRIG_SAMPLE_W - DTRIG_NARROW_W;

	// Sensitivity band in percent of full scale, rounded up to whole counts.
	localparam int DTRIG_HYST_PERCENT = 2;
	localparam int DTRIG_FULL_SCALE   = 1 << DTRIG_SAMPLE_W;
	localparam int DTRIG_HYST_COUNTS  = (DTRIG_FULL_SCALE * DTRIG_HYST_PERCENT + 99) / 100;

	localparam int DTRIG_TMO_W       = 32;
	localparam logic [DTRIG_TMO_W-1:0] DTRIG_TMO_RESET = 32'h0;
	localparam logic [DTRIG_TMO_W-1:0] DTRIG_TMO_STEP  = 32'h1;

	// Acquisition memory of 2**32 sample words.
	localparam int DTRIG_MEM_AW      = 32;

	typedef enum logic [1:0] {
		DTRIG_SRC_CH0,
		DTRIG_SRC_CH1,
		DTRIG_SRC_EXT,
		DTRIG_SRC_SOFT
	} dtrig_src_t;

	typedef enum logic {
		DTRIG_SLOPE_POS,
		DTRIG_SLOPE_NEG
	} dtrig_slope_t;

endpackage

// ---- dtrig_engine.sv ----
// One trigger engine: level crossing with slope and hysteresis.
// Assumes a synchronous sample stream and an already edge-detected soft pulse.
`timescale 1ns/1ns
`default_nettype none
module dtrig_engine (
	input  wire logic                                  clk,
	input  wire logic                                  rst_n,
	input  wire logic                                  enable,
	input  wire logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]  sample,
	input  wire logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]  level,
	input  wire dtrig_pkg::dtrig_slope_t               slope,
	input  wire logic                                  soft_sel,
	input  wire logic                                  soft_pulse,
	output logic                                       fire_q
);
	import dtrig_pkg::*;

	typedef enum {ENG_WAIT, ENG_ARMED} dtrig_eng_state_t;

	localparam logic signed [DTRIG_SAMPLE_W:0] HYST = (DTRIG_SAMPLE_W+1)'(DTRIG_HYST_COUNTS);

	dtrig_eng_state_t state_q, state_d;
	logic fire_d;

	wire signed [DTRIG_SAMPLE_W:0] smp = {sample[DTRIG_SAMPLE_W-1], sample};
	wire signed [DTRIG_SAMPLE_W:0] lvl = {level[DTRIG_SAMPLE_W-1], level};
	wire is_pos   = (slope == DTRIG_SLOPE_POS);
	// The source must first sit a full band on the far side of the level.
	wire arm_cond = is_pos ? (smp <= lvl - HYST) : (smp >= lvl + HYST);
	wire hit_cond = is_pos ? (smp >= lvl) : (smp <= lvl);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ENG_WAIT: if (arm_cond) state_d = ENG_ARMED;
			ENG_ARMED: if (hit_cond) state_d = ENG_WAIT;
			default: state_d = ENG_WAIT;
		endcase
		if (!enable || soft_sel) state_d = ENG_WAIT;
	end

	assign fire_d = enable & (soft_sel ? soft_pulse : (state_q == ENG_ARMED) & hit_cond);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ENG_WAIT;
			fire_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			fire_q  <= fire_d;
		end
	end

	a_fire_needs_arm: assert property (@(posedge clk) disable iff (!rst_n)
		fire_q |-> $past(soft_sel) || $past(state_q == ENG_ARMED))
		else $error("engine fired without prior swing through the band");
	a_fire_rising: assert property (@(posedge clk) disable iff (!rst_n)
		fire_q && !$past(soft_sel) && $past(slope == DTRIG_SLOPE_POS) |-> $past(smp >= lvl))
		else $error("positive slope fire below level");
	a_fire_falling: assert property (@(posedge clk) disable iff (!rst_n)
		fire_q && !$past(soft_sel) && $past(slope == DTRIG_SLOPE_NEG) |-> $past(smp <= lvl))
		else $error("negative slope fire above level");
	a_fire_single: assert property (@(posedge clk) disable iff (!rst_n)
		fire_q |=> !fire_q)
		else $error("engine fire longer than one cycle");
	a_engine_off: assert property (@(posedge clk) disable iff (!rst_n)
		!enable |=> !fire_q)
		else $error("disabled engine fired");
endmodule
`default_nettype wire

// ---- dtrig_memsplit.sv ----
// Write addressing that shares acquisition memory among active channels.
// Assumes one sample per channel per clock while capture runs.
`timescale 1ns/1ns
`default_nettype none
module dtrig_memsplit #(
	parameter int AW = dtrig_pkg::DTRIG_MEM_AW
) (
	input  wire logic                                  clk,
	input  wire logic                                  rst_n,
	input  wire logic                                  run,
	input  wire logic                                  dual,
	input  wire logic                                  single_ch,
	input  wire logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]  ch0_data,
	input  wire logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]  ch1_data,
	output logic                                       wr0_en_q,
	output logic [AW-1:0]                              wr0_addr_q,
	output logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]       wr0_data_q,
	output logic                                       wr1_en_q,
	output logic [AW-1:0]                              wr1_addr_q,
	output logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]       wr1_data_q
);
	import dtrig_pkg::*;

	// In dual mode each channel owns one half; alone a channel owns it all.
	function automatic logic [AW-1:0] region_addr(input logic [AW-1:0] ptr, input logic two, input logic upper);
		region_addr = two ? {upper, ptr[AW-2:0]} : ptr;
	endfunction

	logic [AW-1:0] ptr0_q, ptr1_q;

	wire act0 = dual | ~single_ch;
	wire act1 = dual | single_ch;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr0_q     <= '0;
			ptr1_q     <= '0;
			wr0_en_q   <= 1'b0;
			wr1_en_q   <= 1'b0;
			wr0_addr_q <= '0;
			wr1_addr_q <= '0;
			wr0_data_q <= '0;
			wr1_data_q <= '0;
		end else begin
			ptr0_q     <= (run && act0) ? ptr0_q + AW'(1) : (run ? ptr0_q : '0);
			ptr1_q     <= (run && act1) ? ptr1_q + AW'(1) : (run ? ptr1_q : '0);
			wr0_en_q   <= run & act0;
			wr1_en_q   <= run & act1;
			wr0_addr_q <= region_addr(ptr0_q, dual, 1'b0);
			wr1_addr_q <= region_addr(ptr1_q, dual, 1'b1);
			wr0_data_q <= ch0_data;
			wr1_data_q <= ch1_data;
		end
	end

	a_dual_lower: assert property (@(posedge clk) disable iff (!rst_n)
		$past(dual) && wr0_en_q |-> !wr0_addr_q[AW-1])
		else $error("channel 0 left its half in dual mode");
	a_dual_upper: assert property (@(posedge clk) disable iff (!rst_n)
		$past(dual) && wr1_en_q |-> wr1_addr_q[AW-1])
		else $error("channel 1 left its half in dual mode");
	a_single_port: assert property (@(posedge clk) disable iff (!rst_n)
		$past(run) && !$past(dual) |-> (wr0_en_q != wr1_en_q))
		else $error("single mode must write exactly one channel");
endmodule
`default_nettype wire

// ---- dtrig_top.sv ----
// Trigger logic top: input staging, sample formatting, engines, timeout and
// the global trigger, plus memory write addressing for the captured samples.
// Assumes converter pins are synchronous to SYS_CLK, while all configuration
// ports are driven by logic on SYS_CLK.
//
// What this block does
// - Simple mode uses one engine with source channel, external or software.
// - An engine fires when its source crosses the level in the chosen slope.
// - A channel or external firing needs a swing through the level of two percent full scale; a software firing does not.
// - An optional timeout forces a trigger when no event came in time.
// - Every engine has its own level and slope; all but the external engine choose their own source.
// - The global trigger is the OR of all engine outputs and the timeout expiry.
// - Two engines per input channel plus one engine for the external input.
// - A window uses two engines on one channel, positive upper, negative lower.
// - Upper engine fires rising above, lower engine fires falling below.
// - Narrow fourteen-bit samples are widened to sixteen bits with zeros.
// - Memory is split equally among the one or two active channels.
// - Dual-channel or single-channel capture is chosen by configuration.
`timescale 1ns/1ns
`default_nettype none
module dtrig_top #(
	parameter int MEM_AW = dtrig_pkg::DTRIG_MEM_AW
) (
	input  wire logic                                                           SYS_CLK,
	input  wire logic                                                           RESET_N,
	input  wire logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]                           ADC0_DATA,
	input  wire logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]                           ADC1_DATA,
	input  wire logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]                           EXT_DATA,
	input  wire logic                                                           NARROW_MODE,
	input  wire logic                                                           SOFT_TRIG,
	input  wire logic                                                           ACQ_RUN,
	input  wire logic                                                           SIMPLE_MODE,
	input  wire logic [dtrig_pkg::DTRIG_NUM_ENG-1:0]                            ENG_ENABLE,
	input  wire dtrig_pkg::dtrig_src_t [dtrig_pkg::DTRIG_NUM_ENG-1:0]           ENG_SRC,
	input  wire logic [dtrig_pkg::DTRIG_NUM_ENG-1:0][dtrig_pkg::DTRIG_SAMPLE_W-1:0] ENG_LEVEL,
	input  wire dtrig_pkg::dtrig_slope_t [dtrig_pkg::DTRIG_NUM_ENG-1:0]         ENG_SLOPE,
	input  wire logic                                                           TIMEOUT_EN,
	input  wire logic [dtrig_pkg::DTRIG_TMO_W-1:0]                              TIMEOUT_CYCLES,
	input  wire logic                                                           DUAL_MODE,
	input  wire logic                                                           SINGLE_CH,
	output logic                                                                TRIG_OUT,
	output logic                                                                TRIG_FORCED,
	output logic [dtrig_pkg::DTRIG_NUM_ENG-1:0]                                 ENGINE_FIRE,
	output logic                                                                CH0_WR_EN,
	output logic [MEM_AW-1:0]                                                   CH0_WR_ADDR,
	output logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]                                CH0_WR_DATA,
	output logic                                                                CH1_WR_EN,
	output logic [MEM_AW-1:0]                                                   CH1_WR_ADDR,
	output logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]                                CH1_WR_DATA
);
	import dtrig_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Narrow converters deliver their code in the low bits; it is moved to the
	// top so that level and hysteresis keep one scale in both variants.
	function automatic logic [DTRIG_SAMPLE_W-1:0] fmt_sample(input logic [DTRIG_SAMPLE_W-1:0] raw,
		input logic narrow);
		fmt_sample = narrow ? {raw[DTRIG_NARROW_W-1:0], {DTRIG_PAD_W{1'b0}}} : raw;
	endfunction

	function automatic logic [DTRIG_SAMPLE_W-1:0] sel_sample(input dtrig_src_t src,
		input logic [DTRIG_NUM_INPUTS-1:0][DTRIG_SAMPLE_W-1:0] f);
		case (src)
			DTRIG_SRC_CH0: sel_sample = f[0];
			DTRIG_SRC_CH1: sel_sample = f[1];
			default: sel_sample = f[DTRIG_EXT_IDX];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Reset release.

	// Reset takes effect at once but is let go only after two clean edges, so
	// no register leaves reset close to a clock edge.
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin staging and sample formatting.

	logic [DTRIG_NUM_INPUTS-1:0][DTRIG_SAMPLE_W-1:0] pin_s1_q;
	logic [DTRIG_NUM_INPUTS-1:0][DTRIG_SAMPLE_W-1:0] pin_s2_q;
	logic [DTRIG_NUM_INPUTS-1:0][DTRIG_SAMPLE_W-1:0] fmt;
	logic                                            soft_q;

	wire [DTRIG_NUM_INPUTS-1:0][DTRIG_SAMPLE_W-1:0] pin_in = {EXT_DATA, ADC1_DATA, ADC0_DATA};

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			soft_q   <= 1'b0;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
			soft_q   <= SOFT_TRIG;
		end
	end

	assign fmt[0]             = fmt_sample(pin_s2_q[0], NARROW_MODE);
	assign fmt[1]             = fmt_sample(pin_s2_q[1], NARROW_MODE);
	// The external input is a full-width word and is never padded.
	assign fmt[DTRIG_EXT_IDX] = pin_s2_q[DTRIG_EXT_IDX];

	// A held software request triggers once, on its rising edge.
	wire soft_pulse = SOFT_TRIG & ~soft_q;

	////////////////////////////////////////////////////////////////////////////
	// Trigger engines.

	logic [DTRIG_NUM_ENG-1:0] eng_fire;

	// Windowed and ORed triggering need no logic of their own: two engines set
	// to one channel with opposite slopes form a window, and the OR below joins
	// every engine into the global trigger.
	for (genvar e = 0; e < DTRIG_NUM_ENG; e++) begin : g_eng
		dtrig_src_t                src_e;
		logic                      en_e;
		logic [DTRIG_SAMPLE_W-1:0] smp_e;

		// The last engine always watches the external input.
		assign src_e = (e == DTRIG_EXT_ENG) ? DTRIG_SRC_EXT : ENG_SRC[e];
		// Simple mode keeps only the first engine alive.
		assign en_e  = ENG_ENABLE[e] & (~SIMPLE_MODE | (e == 0));
		assign smp_e = sel_sample(src_e, fmt);

		dtrig_engine u_engine (
			.clk        (SYS_CLK),
			.rst_n      (rst_n_q),
			.enable     (en_e),
			.sample     (smp_e),
			.level      (ENG_LEVEL[e]),
			.slope      (ENG_SLOPE[e]),
			.soft_sel   (src_e == DTRIG_SRC_SOFT),
			.soft_pulse (soft_pulse),
			.fire_q     (eng_fire[e])
		);
	end

	assign ENGINE_FIRE = eng_fire;

	////////////////////////////////////////////////////////////////////////////
	// Timeout and global trigger.

	logic [DTRIG_TMO_W-1:0] tmo_q;
	logic                   trig_q;
	logic                   forced_q;

	// The wait counts sampling clocks while capture runs. Reaching the programmed
	// count with no engine event forces one trigger and starts a new wait.
	wire eng_any    = |eng_fire;
	wire tmo_count  = TIMEOUT_EN && ACQ_RUN && (TIMEOUT_CYCLES != DTRIG_TMO_RESET);
	wire tmo_expire = tmo_count && !eng_any && (tmo_q == TIMEOUT_CYCLES - DTRIG_TMO_STEP);

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tmo_q    <= DTRIG_TMO_RESET;
			trig_q   <= 1'b0;
			forced_q <= 1'b0;
		end else begin
			// Any real trigger restarts the wait.
			tmo_q    <= (!tmo_count || eng_any || tmo_expire) ? DTRIG_TMO_RESET : tmo_q + DTRIG_TMO_STEP;
			trig_q   <= eng_any | tmo_expire;
			forced_q <= tmo_expire;
		end
	end

	assign TRIG_OUT    = trig_q;
	assign TRIG_FORCED = forced_q;

	////////////////////////////////////////////////////////////////////////////
	// Acquisition memory addressing.

	// In dual mode channel 1 writes the upper half of the address space; a
	// single active channel uses the whole space from address zero.
	dtrig_memsplit #(
		.AW (MEM_AW)
	) u_memsplit (
		.clk        (SYS_CLK),
		.rst_n      (rst_n_q),
		.run        (ACQ_RUN),
		.dual       (DUAL_MODE),
		.single_ch  (SINGLE_CH),
		.ch0_data   (fmt[0]),
		.ch1_data   (fmt[1]),
		.wr0_en_q   (CH0_WR_EN),
		.wr0_addr_q (CH0_WR_ADDR),
		.wr0_data_q (CH0_WR_DATA),
		.wr1_en_q   (CH1_WR_EN),
		.wr1_addr_q (CH1_WR_ADDR),
		.wr1_data_q (CH1_WR_DATA)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks of the trigger path.
	// Engine-level checks sit inside each engine; the ones here watch how the
	// engines and the global trigger work together.

	a_reset_quiet: assert property (@(posedge SYS_CLK)
		!rst_n_q |-> !TRIG_OUT && !TRIG_FORCED && ENGINE_FIRE == '0)
		else $error("trigger output active during reset");

	a_global_or: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		eng_any |=> TRIG_OUT)
		else $error("engine fire did not reach the global trigger");

	a_global_cause: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		TRIG_OUT |-> $past(eng_any) || TRIG_FORCED)
		else $error("global trigger without a cause");

	a_soft_trigger: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		soft_pulse && ENG_ENABLE[0] && ENG_SRC[0] == DTRIG_SRC_SOFT |=> ENGINE_FIRE[0] ##1 TRIG_OUT)
		else $error("software request did not trigger");

	a_soft_once: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		soft_pulse |=> !soft_pulse)
		else $error("held software request triggered twice");

	a_simple_single: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		SIMPLE_MODE |=> ENGINE_FIRE[DTRIG_NUM_ENG-1:1] == '0)
		else $error("engine other than the first fired in simple mode");

	a_ext_enable: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		ENGINE_FIRE[DTRIG_EXT_ENG] |-> $past(ENG_ENABLE[DTRIG_EXT_ENG]) && !$past(SIMPLE_MODE))
		else $error("external engine fired while switched off");

	////////////////////////////////////////////////////////////////////////////
	// Checks of the timeout.
	// A forced trigger only stands in for a missing engine event, so it never
	// appears while counting is off or right after a real trigger.

	a_timeout_force: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		TRIG_FORCED |-> $past(tmo_q) == $past(TIMEOUT_CYCLES) - DTRIG_TMO_STEP && $past(TIMEOUT_EN))
		else $error("forced trigger at the wrong count");

	a_timeout_fires: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		tmo_expire |=> TRIG_FORCED && TRIG_OUT)
		else $error("expired timeout did not force a trigger");

	a_forced_pulse: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		TRIG_FORCED |=> !TRIG_FORCED)
		else $error("forced trigger longer than one cycle");

	a_forced_global: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		TRIG_FORCED |-> TRIG_OUT)
		else $error("forced trigger missing on the global trigger");

	a_timeout_idle: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		!(TIMEOUT_EN && ACQ_RUN) |=> !TRIG_FORCED)
		else $error("forced trigger while the timeout was off");

	a_timeout_restart: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		eng_any |=> tmo_q == DTRIG_TMO_RESET && !TRIG_FORCED)
		else $error("engine event did not restart the timeout");

	////////////////////////////////////////////////////////////////////////////
	// Checks of the capture path.

	a_narrow_pad: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		$past(NARROW_MODE) && CH0_WR_EN |-> CH0_WR_DATA[DTRIG_PAD_W-1:0] == '0)
		else $error("narrow sample not padded with zeros");

	a_narrow_pad_ch1: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		$past(NARROW_MODE) && CH1_WR_EN |-> CH1_WR_DATA[DTRIG_PAD_W-1:0] == '0)
		else $error("narrow channel 1 sample not padded with zeros");

	a_dual_both: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		$past(ACQ_RUN) && $past(DUAL_MODE) |-> CH0_WR_EN && CH1_WR_EN)
		else $error("dual mode did not write both channels");

	a_run_stopped: assert property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		!ACQ_RUN |=> !CH0_WR_EN && !CH1_WR_EN)
		else $error("memory written while capture was stopped");

	////////////////////////////////////////////////////////////////////////////
	// Scenarios that the bench is expected to reach.

	c_window: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		ENGINE_FIRE[2] ##[1:100] ENGINE_FIRE[3]);

	c_forced: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		TRIG_FORCED);

	c_external: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		ENGINE_FIRE[DTRIG_EXT_ENG] ##1 TRIG_OUT);

	c_dual: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		DUAL_MODE && CH0_WR_EN && CH1_WR_EN);

	c_soft: cover property (@(posedge SYS_CLK) disable iff (!rst_n_q)
		soft_pulse ##1 ENGINE_FIRE[0] ##1 TRIG_OUT);
endmodule
`default_nettype wire

// ---- dtrig_adc_model.sv ----
// Behavioural model of the two converters and the digitized external input.
// Assumes the bench sets the wanted codes; the outputs change on falling edges.
`timescale 1ns/1ns
`default_nettype none
module dtrig_adc_model (
	input  wire logic                                  clk,
	output logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]       ch0,
	output logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]       ch1,
	output logic [dtrig_pkg::DTRIG_SAMPLE_W-1:0]       ext
);
	import dtrig_pkg::*;
	logic [DTRIG_SAMPLE_W-1:0] want [DTRIG_NUM_INPUTS];
	////////////////////////////////////////////////////////////////////////////
	initial begin
		want = '{default: '0};
		ch0 = '0;
		ch1 = '0;
		ext = '0;
	end
	// Each converter presents one new code per sampling clock.
	always @(negedge clk) begin
		ch0 <= want[0];
		ch1 <= want[1];
		ext <= want[DTRIG_EXT_IDX];
	end
	task automatic set_value(input int idx, input logic [DTRIG_SAMPLE_W-1:0] v);
		want[idx] <= v;
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench of the trigger logic top with converter model.
// Assumes a 10 MHz sampling clock and inputs driven on falling edges.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import dtrig_pkg::*;
	localparam int AW = 8;
	logic                                     sys_clk = 1'b0;
	logic                                     reset_n = 1'b0;
	logic [DTRIG_SAMPLE_W-1:0]                adc0, adc1, ext;
	logic                                     narrow = 1'b0, soft_trig = 1'b0, acq_run = 1'b0, simple = 1'b0;
	logic [DTRIG_NUM_ENG-1:0]                 eng_enable = '0;
	dtrig_src_t [DTRIG_NUM_ENG-1:0]           eng_src = '{default: DTRIG_SRC_CH0};
	logic [DTRIG_NUM_ENG-1:0][DTRIG_SAMPLE_W-1:0] eng_level = '0;
	dtrig_slope_t [DTRIG_NUM_ENG-1:0]         eng_slope = '{default: DTRIG_SLOPE_POS};
	logic                                     tmo_en = 1'b0, dual = 1'b1, single_ch = 1'b0;
	logic [DTRIG_TMO_W-1:0]                   tmo_cycles = '0;
	logic                                     trig_out, trig_forced, wr0_en, wr1_en;
	logic [DTRIG_NUM_ENG-1:0]                 engine_fire;
	logic [AW-1:0]                            wr0_addr, wr1_addr;
	logic [DTRIG_SAMPLE_W-1:0]                wr0_data, wr1_data;
	int                                       bad_count = 0, check_count = 0;
	int                                       fire_cnt [DTRIG_NUM_ENG];
	int                                       trig_cnt, last;
	////////////////////////////////////////////////////////////////////////////
	always #50 sys_clk = ~sys_clk;
	dtrig_adc_model dtrig_adc_model_i (.clk(sys_clk), .ch0(adc0), .ch1(adc1), .ext(ext));
	dtrig_top #(.MEM_AW(AW)) dtrig_top_i (
		.SYS_CLK(sys_clk), .RESET_N(reset_n), .ADC0_DATA(adc0), .ADC1_DATA(adc1), .EXT_DATA(ext),
		.NARROW_MODE(narrow), .SOFT_TRIG(soft_trig), .ACQ_RUN(acq_run), .SIMPLE_MODE(simple),
		.ENG_ENABLE(eng_enable), .ENG_SRC(eng_src), .ENG_LEVEL(eng_level), .ENG_SLOPE(eng_slope),
		.TIMEOUT_EN(tmo_en), .TIMEOUT_CYCLES(tmo_cycles), .DUAL_MODE(dual), .SINGLE_CH(single_ch),
		.TRIG_OUT(trig_out), .TRIG_FORCED(trig_forced), .ENGINE_FIRE(engine_fire),
		.CH0_WR_EN(wr0_en), .CH0_WR_ADDR(wr0_addr), .CH0_WR_DATA(wr0_data),
		.CH1_WR_EN(wr1_en), .CH1_WR_ADDR(wr1_addr), .CH1_WR_DATA(wr1_data));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Counts pulses over a span; a software request is a single rising edge.
	task automatic observe(input int n);
		fire_cnt = '{default: 0};
		trig_cnt = 0;
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk);
			soft_trig = 1'b0;
			for (int e = 0; e < DTRIG_NUM_ENG; e++) if (engine_fire[e] === 1'b1) fire_cnt[e]++;
			if (trig_out === 1'b1) trig_cnt++;
		end
	endtask
	task automatic fire_case(input int e, input int src, input logic neg, input int lv, input int lo,
			input int hi, input int expn);
		eng_enable = '0;
		eng_src[e] = dtrig_src_t'(src);
		eng_slope[e] = dtrig_slope_t'(neg);
		eng_level[e] = DTRIG_SAMPLE_W'(lv);
		if (src < 3) dtrig_adc_model_i.set_value(src, DTRIG_SAMPLE_W'(lo));
		step(2);
		eng_enable[e] = 1'b1;
		step(4);
		if (src < 3) dtrig_adc_model_i.set_value(src, DTRIG_SAMPLE_W'(hi));
		else soft_trig = 1'b1;
		observe(8);
		chk("engine fire count", 32'(expn), 32'(fire_cnt[e]));
		chk("global trigger count", 32'(expn), 32'(trig_cnt));
	endtask
	task automatic mem_case(input logic d, input logic sel, input logic nar, input logic [15:0] v0,
			input logic [15:0] v1);
		logic [15:0] x0, x1;
		acq_run = 1'b0;
		dual = d;
		single_ch = sel;
		narrow = nar;
		dtrig_adc_model_i.set_value(0, v0);
		dtrig_adc_model_i.set_value(1, v1);
		x0 = nar ? {v0[13:0], 2'b00} : v0;
		x1 = nar ? {v1[13:0], 2'b00} : v1;
		step(5);
		acq_run = 1'b1;
		for (int i = 0; i < 6 && wr0_en !== 1'b1 && wr1_en !== 1'b1; i++) step(1);
		for (int k = 0; k < 2; k++) begin
			chk("ch0 write enable", 32'(d | !sel), 32'(wr0_en));
			chk("ch1 write enable", 32'(d | sel), 32'(wr1_en));
			if (d | !sel) chk("ch0 address", 32'(k), 32'(wr0_addr));
			if (d) chk("ch1 address", 32'(k + (1 << (AW - 1))), 32'(wr1_addr));
			if (!d & sel) chk("ch1 address", 32'(k), 32'(wr1_addr));
			if (d | !sel) chk("ch0 data", 32'(x0), 32'(wr0_data));
			if (d | sel) chk("ch1 data", 32'(x1), 32'(wr1_data));
			step(1);
		end
		acq_run = 1'b0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#(5000 * 100);
		bad_count++;
		conclude();
	end
	initial begin
		step(6);
		reset_n = 1'b1;
		step(5);
		// Every channel engine against every source, then the external engine.
		for (int e = 0; e < 4; e++)
			for (int s = 0; s < 4; s++) fire_case(e, s, 1'b0, 0, -2000, 100, 1);
		fire_case(4, 2, 1'b0, 0, -2000, 100, 1);
		fire_case(3, 1, 1'b1, 500, 2000, 400, 1);
		fire_case(0, 0, 1'b0, 0, -1310, 100, 0);
		fire_case(0, 0, 1'b0, 0, -1311, 0, 1);
		fire_case(2, 1, 1'b1, 0, 1310, -100, 0);
		simple = 1'b1;
		fire_case(1, 0, 1'b0, 0, -2000, 100, 0);
		fire_case(0, 3, 1'b0, 0, 0, 0, 1);
		simple = 1'b0;
		// Window of two engines on channel 1.
		eng_enable = '0;
		eng_src[2] = DTRIG_SRC_CH1;
		eng_src[3] = DTRIG_SRC_CH1;
		eng_slope[2] = DTRIG_SLOPE_POS;
		eng_slope[3] = DTRIG_SLOPE_NEG;
		eng_level[2] = 16'h03e8;
		eng_level[3] = 16'hfc18;
		dtrig_adc_model_i.set_value(1, 16'hfe70);
		step(2);
		eng_enable = 5'h0c;
		step(4);
		dtrig_adc_model_i.set_value(1, 16'h044c);
		observe(8);
		chk("upper fire", 32'h1, 32'(fire_cnt[2]));
		chk("lower fire", 32'h0, 32'(fire_cnt[3]));
		chk("window trigger", 32'h1, 32'(trig_cnt));
		dtrig_adc_model_i.set_value(1, 16'hfbb4);
		observe(8);
		chk("upper fire", 32'h0, 32'(fire_cnt[2]));
		chk("lower fire", 32'h1, 32'(fire_cnt[3]));
		chk("window trigger", 32'h1, 32'(trig_cnt));
		// Forced trigger every five cycles with no engine enabled.
		eng_enable = '0;
		tmo_cycles = 32'h5;
		tmo_en = 1'b1;
		acq_run = 1'b1;
		last = -1;
		trig_cnt = 0;
		for (int i = 0; i < 30; i++) begin
			step(1);
			if (trig_forced === 1'b1) begin
				chk("trigger with force", 32'h1, 32'(trig_out));
				if (last >= 0) chk("force interval", 32'h5, 32'(i - last));
				last = i;
				trig_cnt++;
			end
		end
		chk("force pulses", 32'h1, 32'(trig_cnt >= 5));
		tmo_en = 1'b0;
		step(8);
		chk("no force when off", 32'h0, 32'(trig_forced));
		mem_case(1'b1, 1'b0, 1'b0, 16'h1234, 16'h5678);
		mem_case(1'b0, 1'b1, 1'b1, 16'h1234, 16'hc321);
		mem_case(1'b0, 1'b0, 1'b1, 16'hbeef, 16'h0001);
		conclude();
	end
endmodule
`default_nettype wire
